// file: hw/emt_pkg.sv
package emt_pkg;
	// timing register location on the special function register bus
	localparam logic [7:0] EMT_TC_PAGE = 8'h00;
	localparam logic [7:0] EMT_TC_ADDR = 8'hAF;
	localparam logic [7:0] EMT_TC_RESET = 8'hFF;
	// field positions inside the timing register
	localparam int EMT_SETUP_MSB = 7;
	localparam int EMT_SETUP_LSB = 6;
	localparam int EMT_WIDTH_MSB = 5;
	localparam int EMT_WIDTH_LSB = 2;
	localparam int EMT_HOLD_MSB = 1;
	localparam int EMT_HOLD_LSB = 0;
	// fixed overhead of an access: one start cycle plus the tail
	localparam int EMT_OVERHEAD_CYCLES = 4;
	localparam logic [3:0] EMT_TAIL_LOAD = 4'(EMT_OVERHEAD_CYCLES - 2);
	// configuration field: bit 2 low selects the shared address/data port
	localparam int EMT_CFG_MUX_BIT = 2;
	localparam logic [1:0] EMT_CFG_INTERNAL = 2'h0;
	localparam logic [1:0] EMT_CFG_BANK = 2'h2;
	typedef enum logic [2:0] {
		EMT_IDLE,
		EMT_START,
		EMT_ALE_HI,
		EMT_ALE_LO,
		EMT_SETUP,
		EMT_STROBE,
		EMT_HOLD,
		EMT_FINISH
	} emt_state_type;
endpackage

// file: hw/emt_ctrl.sv
`timescale 1ns/1ps
module emt_ctrl
(
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic [7:0] SFR_PAGE,
	input wire logic [7:0] SFR_ADDR,
	input wire logic SFR_WR,
	input wire logic [7:0] SFR_WDATA,
	output logic [7:0] SFR_RDATA,
	input wire logic [2:0] EXT_MEM_CONFIG,
	input wire logic [1:0] ALE_WIDTH,
	input wire logic [7:0] XRAM_BANK_SELECT,
	input wire logic REQ,
	input wire logic REQ_WRITE,
	input wire logic REQ_WIDE,
	input wire logic [15:0] REQ_ADDR,
	input wire logic [7:0] REQ_WDATA,
	output logic BUSY,
	output logic DONE,
	output logic [7:0] RDATA,
	output logic [7:0] ADDR_HI,
	output logic ADDR_HI_OE,
	output logic [7:0] ADDR_LO,
	output logic ADDR_LO_OE,
	output logic [7:0] AD_OUT,
	output logic AD_OE,
	input wire logic [7:0] AD_IN,
	output logic ALE,
	output logic RD_N,
	output logic WR_N
);
	import emt_pkg::*;

	logic [7:0] timing;
	logic [7:0] next_timing;
	logic [7:0] next_sfr_rdata;
	logic sfr_hit;

	emt_state_type state;
	emt_state_type next_state;
	logic [3:0] cnt;
	logic [3:0] next_cnt;
	logic write;
	logic next_write;
	logic mux;
	logic next_mux;
	logic hi_en;
	logic next_hi_en;
	logic [15:0] addr;
	logic [15:0] next_addr;
	logic [7:0] wdata;
	logic [7:0] next_wdata;
	logic [7:0] next_rdata;
	logic next_done;

	logic next_addr_hi_oe;
	logic next_addr_lo_oe;
	logic [7:0] next_ad_out;
	logic next_ad_oe;
	logic next_ale;
	logic next_rd_n;
	logic next_wr_n;

	logic [1:0] setup_f;
	logic [3:0] width_f;
	logic [1:0] hold_f;
	logic addr_phase;
	logic data_phase;

	assign setup_f = timing[EMT_SETUP_MSB:EMT_SETUP_LSB];
	assign width_f = timing[EMT_WIDTH_MSB:EMT_WIDTH_LSB];
	assign hold_f = timing[EMT_HOLD_MSB:EMT_HOLD_LSB];

	// register access; reads of other addresses return zero
	always_comb
	begin
		sfr_hit = (SFR_PAGE == EMT_TC_PAGE) && (SFR_ADDR == EMT_TC_ADDR);
		next_timing = timing;
		if (SFR_WR && sfr_hit)
		begin
			next_timing = SFR_WDATA;
		end
		next_sfr_rdata = sfr_hit ? timing : 8'h00;
	end

	always_ff @(posedge CLK)
	begin
		if (!RSTN)
		begin
			timing <= EMT_TC_RESET;
			SFR_RDATA <= 8'h00;
		end
		else
		begin
			timing <= next_timing;
			SFR_RDATA <= next_sfr_rdata;
		end
	end

	// access sequencer
	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		next_write = write;
		next_mux = mux;
		next_hi_en = hi_en;
		next_addr = addr;
		next_wdata = wdata;
		next_rdata = RDATA;
		next_done = 1'b0;
		unique case (state)
			EMT_IDLE:
			begin
				// config x00 keeps all accesses on chip, so nothing goes out
				if (REQ && (EXT_MEM_CONFIG[1:0] != EMT_CFG_INTERNAL))
				begin
					next_state = EMT_START;
					next_write = REQ_WRITE;
					next_addr = REQ_ADDR;
					next_wdata = REQ_WDATA;
					next_mux = !EXT_MEM_CONFIG[EMT_CFG_MUX_BIT];
					// upper byte only for wide accesses or bank select mode
					next_hi_en = REQ_WIDE || (EXT_MEM_CONFIG[1:0] == EMT_CFG_BANK);
					if (!REQ_WIDE && (EXT_MEM_CONFIG[1:0] == EMT_CFG_BANK))
					begin
						next_addr[15:8] = XRAM_BANK_SELECT;
					end
				end
			end
			EMT_START:
			begin
				if (mux)
				begin
					next_state = EMT_ALE_HI;
					next_cnt = {2'b00, ALE_WIDTH};
				end
				else if (setup_f != 2'b00)
				begin
					next_state = EMT_SETUP;
					next_cnt = {2'b00, setup_f - 2'b01};
				end
				else
				begin
					next_state = EMT_STROBE;
					next_cnt = width_f;
				end
			end
			EMT_ALE_HI:
			begin
				if (cnt == 4'h0)
				begin
					next_state = EMT_ALE_LO;
					next_cnt = {2'b00, ALE_WIDTH};
				end
				else
				begin
					next_cnt = cnt - 4'h1;
				end
			end
			EMT_ALE_LO:
			begin
				if (cnt != 4'h0)
				begin
					next_cnt = cnt - 4'h1;
				end
				else if (setup_f != 2'b00)
				begin
					next_state = EMT_SETUP;
					next_cnt = {2'b00, setup_f - 2'b01};
				end
				else
				begin
					next_state = EMT_STROBE;
					next_cnt = width_f;
				end
			end
			EMT_SETUP:
			begin
				if (cnt == 4'h0)
				begin
					next_state = EMT_STROBE;
					next_cnt = width_f;
				end
				else
				begin
					next_cnt = cnt - 4'h1;
				end
			end
			EMT_STROBE:
			begin
				if (cnt != 4'h0)
				begin
					next_cnt = cnt - 4'h1;
				end
				else
				begin
					// sample read data on the last strobe cycle
					if (!write)
					begin
						next_rdata = AD_IN;
					end
					if (hold_f != 2'b00)
					begin
						next_state = EMT_HOLD;
						next_cnt = {2'b00, hold_f - 2'b01};
					end
					else
					begin
						next_state = EMT_FINISH;
						next_cnt = EMT_TAIL_LOAD;
					end
				end
			end
			EMT_HOLD:
			begin
				if (cnt == 4'h0)
				begin
					next_state = EMT_FINISH;
					next_cnt = EMT_TAIL_LOAD;
				end
				else
				begin
					next_cnt = cnt - 4'h1;
				end
			end
			EMT_FINISH:
			begin
				if (cnt == 4'h0)
				begin
					next_state = EMT_IDLE;
					next_done = 1'b1;
				end
				else
				begin
					next_cnt = cnt - 4'h1;
				end
			end
		endcase
	end

	// pins are computed from the next state so they leave flip-flops aligned to it
	always_comb
	begin
		addr_phase = (next_state != EMT_IDLE) && (next_state != EMT_FINISH);
		data_phase = (next_state == EMT_SETUP) || (next_state == EMT_STROBE) || (next_state == EMT_HOLD);
		next_addr_hi_oe = addr_phase && next_hi_en;
		next_addr_lo_oe = addr_phase && !next_mux;
		next_ale = next_state == EMT_ALE_HI;
		next_rd_n = !((next_state == EMT_STROBE) && !next_write);
		next_wr_n = !((next_state == EMT_STROBE) && next_write);
		next_ad_oe = 1'b0;
		next_ad_out = 8'h00;
		// low address stays on the shared port through the low phase for latch hold
		if (next_mux && ((next_state == EMT_START) || (next_state == EMT_ALE_HI) || (next_state == EMT_ALE_LO)))
		begin
			next_ad_oe = 1'b1;
			next_ad_out = next_addr[7:0];
		end
		else if (data_phase && next_write)
		begin
			next_ad_oe = 1'b1;
			next_ad_out = next_wdata;
		end
	end

	always_ff @(posedge CLK)
	begin
		if (!RSTN)
		begin
			state <= EMT_IDLE;
			cnt <= 4'h0;
			write <= 1'b0;
			mux <= 1'b0;
			hi_en <= 1'b0;
			addr <= 16'h0000;
			wdata <= 8'h00;
			RDATA <= 8'h00;
			DONE <= 1'b0;
			BUSY <= 1'b0;
			ADDR_HI <= 8'h00;
			ADDR_HI_OE <= 1'b0;
			ADDR_LO <= 8'h00;
			ADDR_LO_OE <= 1'b0;
			AD_OUT <= 8'h00;
			AD_OE <= 1'b0;
			ALE <= 1'b0;
			RD_N <= 1'b1;
			WR_N <= 1'b1;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			write <= next_write;
			mux <= next_mux;
			hi_en <= next_hi_en;
			addr <= next_addr;
			wdata <= next_wdata;
			RDATA <= next_rdata;
			DONE <= next_done;
			BUSY <= next_state != EMT_IDLE;
			ADDR_HI <= next_addr[15:8];
			ADDR_HI_OE <= next_addr_hi_oe;
			ADDR_LO <= next_addr[7:0];
			ADDR_LO_OE <= next_addr_lo_oe;
			AD_OUT <= next_ad_out;
			AD_OE <= next_ad_oe;
			ALE <= next_ale;
			RD_N <= next_rd_n;
			WR_N <= next_wr_n;
		end
	end
endmodule

// file: tb/emt_ctrl_chk.sv
`timescale 1ns/1ps
module emt_ctrl_chk
(
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic [2:0] EXT_MEM_CONFIG,
	input wire logic REQ_WIDE,
	input wire logic BUSY,
	input wire logic DONE,
	input wire logic ADDR_HI_OE,
	input wire logic ADDR_LO_OE,
	input wire logic AD_OE,
	input wire logic ALE,
	input wire logic RD_N,
	input wire logic WR_N
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);
	strobe_excl_a: assert property (RD_N || WR_N) else $error("both strobes low");
	ale_mux_a: assert property (ALE |-> AD_OE && !EXT_MEM_CONFIG[2]) else $error("bad latch pulse");
	ale_phase_a: assert property ($rose(ALE) |-> ##[1:4] !ALE) else $error("latch high too long");
	lo_pins_a: assert property (ADDR_LO_OE |-> EXT_MEM_CONFIG[2]) else $error("low pins in muxed mode");
	wr_data_a: assert property (!WR_N |-> AD_OE) else $error("write data not driven");
	done_pulse_a: assert property (DONE |=> !DONE) else $error("done too long");
	busy_done_a: assert property (DONE |-> !BUSY) else $error("busy at done");
	min_len_a: assert property ($rose(BUSY) |-> BUSY[*5]) else $error("access too short");
	upper_oe_a: assert property (ADDR_HI_OE |-> REQ_WIDE || EXT_MEM_CONFIG[1:0] == 2'h2) else $error("upper byte driven");
	cover property ($fell(ALE));
	cover property ($rose(WR_N));
	cover property (DONE && !EXT_MEM_CONFIG[2]);
endmodule
bind emt_ctrl emt_ctrl_chk u_chk (.*);

// file: tb/emt_mem.sv
`timescale 1ns/1ps
module emt_mem
(
	input wire logic CLK,
	input wire logic [7:0] ADDR_LO,
	input wire logic ADDR_LO_OE,
	input wire logic [7:0] AD_OUT,
	input wire logic ALE,
	input wire logic RD_N,
	input wire logic WR_N,
	output logic [7:0] AD_IN
);
	logic [7:0] mem [256];
	logic [7:0] lat = 8'h00;
	logic [7:0] tog = 8'h5A;
	// released bus toggles so a stale byte never passes
	assign AD_IN = RD_N ? tog : mem[ADDR_LO_OE ? ADDR_LO : lat];
	always @(posedge CLK)
	begin
		tog <= ~tog;
		if (ALE)
			lat <= AD_OUT; // holds once latch enable falls
		if (!WR_N)
			mem[ADDR_LO_OE ? ADDR_LO : lat] <= AD_OUT;
	end
endmodule

// file: tb/ext_mem_bus_timing_ctrl_bench.sv
`timescale 1ns/1ps
module ext_mem_bus_timing_ctrl_bench;
	import emt_pkg::*;
	logic CLK = 0, RSTN = 0, SFR_WR = 0, REQ = 0, REQ_WRITE = 0, REQ_WIDE = 0, hi;
	logic [7:0] SFR_PAGE = 8'h00, SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, XRAM_BANK_SELECT = 8'hC3, REQ_WDATA = 8'h00;
	logic [2:0] EXT_MEM_CONFIG = 3'h5;
	logic [1:0] ALE_WIDTH = 2'h0;
	logic [15:0] REQ_ADDR = 16'h0000;
	logic [7:0] SFR_RDATA, RDATA, ADDR_HI, ADDR_LO, AD_OUT, AD_IN, hv, d;
	logic BUSY, DONE, ADDR_HI_OE, ADDR_LO_OE, AD_OE, ALE, RD_N, WR_N;
	int fails = 0, checked = 0, cyc = 0, n, s, b, al;
	always #50 CLK = ~CLK;
	emt_ctrl DUT (.*);
	emt_mem mem (.*);
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e)
		begin
			fails++;
			$display("CHECK FAILED %0t %h %h", $time, g, e);
		end
	endtask
	task automatic end_of_test();
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge CLK)
	begin
		cyc++;
		// far above the few hundred cycles the run needs
		if (cyc == 3000)
		begin
			fails++;
			end_of_test();
		end
	end
	task automatic tc_wr(input logic [7:0] v);
		@(posedge CLK);
		{SFR_ADDR, SFR_WDATA, SFR_WR} <= {EMT_TC_ADDR, v, 1'b1};
		@(posedge CLK);
		SFR_WR <= 1'b0;
	endtask
	task automatic sfr_rd(input logic [7:0] a);
		@(posedge CLK);
		SFR_ADDR <= a;
		@(posedge CLK);
		@(negedge CLK);
		d = SFR_RDATA;
	endtask
	task automatic acc(input logic [2:0] c, input logic [1:0] aw, input logic w, input logic wd,
		input logic [15:0] a, input logic [7:0] v);
		@(posedge CLK);
		{EXT_MEM_CONFIG, ALE_WIDTH, REQ, REQ_WRITE, REQ_WIDE, REQ_ADDR, REQ_WDATA} <= {c, aw, 1'b1, w, wd, a, v};
		@(posedge CLK);
		REQ <= 1'b0;
		n = 0;
		s = 0;
		b = 0;
		al = 0;
		hi = 0;
		hv = 8'h00;
		do
		begin
			@(negedge CLK);
			n++;
			s += int'(!RD_N || !WR_N);
			b += int'(BUSY);
			al += int'(ALE);
			hi |= ADDR_HI_OE;
			if (ADDR_HI_OE)
				hv = ADDR_HI;
		end
		while (DONE !== 1'b1 && n < 40);
	endtask
	task automatic t_nonmux();
		logic [7:0] tv [3] = '{8'hFF, 8'h49, 8'h00};
		sfr_rd(8'hAE);
		chk(d, 8'h00);
		foreach (tv[i])
		begin
			sfr_rd(EMT_TC_ADDR);
			chk(d, i ? tv[i - 1] : 8'hFF);
			tc_wr(tv[i]);
			acc(3'h5, 2'h0, 1'b1, 1'b1, {8'h12, 8'(i)}, 8'hA0 + 8'(i));
			// done comes one cycle after the last busy cycle
			chk(n, EMT_OVERHEAD_CYCLES + 2 + tv[i][7:6] + tv[i][5:2] + tv[i][1:0]);
			chk(b, EMT_OVERHEAD_CYCLES + 1 + tv[i][7:6] + tv[i][5:2] + tv[i][1:0]);
			chk(s, tv[i][5:2] + 1);
			chk(hv, 8'h12);
			acc(3'h7, 2'h0, 1'b0, 1'b1, {8'h12, 8'(i)}, 8'h00);
			chk(RDATA, 8'hA0 + 8'(i));
		end
	endtask
	task automatic t_mux();
		for (int a = 0; a < 4; a += 3)
		begin
			acc(3'h1, 2'(a), 1'b1, 1'b1, 16'h0055, 8'h3C + 8'(a));
			chk(n, 8 + 2 * a);
			chk(b, EMT_OVERHEAD_CYCLES + 1 + 2 * (a + 1));
			chk(al, a + 1);
			acc(3'h3, 2'(a), 1'b0, 1'b1, 16'h0055, 8'h00);
			chk(RDATA, 8'h3C + 8'(a));
		end
	endtask
	task automatic t_bank();
		logic [2:0] cf [4] = '{3'h6, 3'h2, 3'h5, 3'h3};
		foreach (cf[i])
		begin
			acc(cf[i], 2'h0, 1'b0, 1'b0, 16'hEE77, 8'h00);
			chk(hi, i < 2);
			chk(hv, i < 2 ? XRAM_BANK_SELECT : 8'h00);
		end
		// internal-only config is never answered
		acc(3'h4, 2'h0, 1'b0, 1'b1, 16'h0001, 8'h00);
		chk(n, 40);
	endtask
	initial
	begin
		repeat (20) @(posedge CLK);
		RSTN <= 1'b1;
		t_nonmux();
		t_mux();
		t_bank();
		end_of_test();
	end
endmodule
